// >>> logic/scc_top.sv
// Serial channel control and configuration with asynchronous transmitter and receiver
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "scc_consts.svh"
module scc_top #(
  parameter bit RETAIN_IN_SW_STANDBY = 1'b0
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       NRST,
  // Register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Power mode requests, levels
  input  wire logic       SW_STANDBY,
  input  wire logic       MODULE_STOP,
  input  wire logic       HW_STANDBY,
  // Serial pins
  input  wire logic       RXD,
  output logic            TXD,
  output logic            SCK_OUT,
  output logic            SCK_OE_N,
  // Interrupt requests
  output logic            TX_EMPTY_IRQ,
  output logic            RX_FULL_IRQ
);
  initial begin
    if (`SCC_OVERSAMPLE != 16) $error("scc_top: oversample must be 16");
  end

  // --------------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------------
  logic [7:0] serial_mode_r,   serial_mode_nxt;
  logic [7:0] bit_rate_r,      bit_rate_nxt;
  logic [7:0] serial_control_r, serial_control_nxt;
  logic [7:0] smart_card_r,    smart_card_nxt;
  logic [7:0] tx_data_r,       tx_data_nxt;
  logic [7:0] rx_data_r,       rx_data_nxt;
  logic       tx_data_empty_flag_r,          tx_data_empty_flag_nxt;
  logic       rdrf_r,          rdrf_nxt;
  logic       fer_r,           fer_nxt;
  logic       tend_r,          tend_nxt;
  logic       tx_data_empty_flag_seen_r,     tx_data_empty_flag_seen_nxt;
  logic       rdrf_seen_r,     rdrf_seen_nxt;
  logic [7:0] rdata_r,         rdata_nxt;
  logic       tx_irq_r,        tx_irq_nxt;
  logic       rx_irq_r,        rx_irq_nxt;
  logic       sck_r,           sck_nxt;
  logic       sck_oe_n_r,      sck_oe_n_nxt;
  // Transmitter
  scc_pkg::scc_state_e tx_st_r, tx_st_nxt;
  logic [7:0] tx_shift_r,      tx_shift_nxt;
  logic [2:0] tx_bit_r,        tx_bit_nxt;
  logic [3:0] tx_ph_r,         tx_ph_nxt;
  logic       txd_r,           txd_nxt;
  // Receiver
  scc_pkg::scc_state_e rx_st_r, rx_st_nxt;
  logic [7:0] rx_shift_r,      rx_shift_nxt;
  logic [2:0] rx_bit_r,        rx_bit_nxt;
  logic [3:0] rx_ph_r,         rx_ph_nxt;
  logic       rxd_m_r, rxd_s_r;
  logic       tick, load, ctrl_clear, tx_en, rx_en, pwr_stop;
  logic [7:0] status;

  assign tx_en    = serial_control_r[`SCC_CTRL_TE];
  assign rx_en    = serial_control_r[`SCC_CTRL_RE];
  assign pwr_stop = SW_STANDBY | MODULE_STOP;
  // Retain variant keeps control across soft standby and module stop
  assign ctrl_clear = HW_STANDBY | (pwr_stop & !RETAIN_IN_SW_STANDBY);
  assign load = (tx_st_r == scc_pkg::SCC_IDLE) && tx_en && !tx_data_empty_flag_r && tick && !pwr_stop;
  assign status = {tx_data_empty_flag_r, rdrf_r, 1'b0, fer_r, 1'b0, tend_r, 1'b0,
                   serial_mode_r[`SCC_MODE_MP]};

  // --------------------------------------------------------------------------
  // Baud generator
  // --------------------------------------------------------------------------
  scc_baud_gen u_baud (
    .clk     (CORE_CLK),
    .nrst    (NRST),
    .run     ((tx_en | rx_en) & !pwr_stop),
    .pre_sel (scc_pkg::scc_pre_e'(serial_mode_r[`SCC_MODE_CKS_LO +: 2])),
    .rate    (bit_rate_r),
    .tick    (tick)
  );

  // --------------------------------------------------------------------------
  // Register file and flags
  // --------------------------------------------------------------------------
  always_comb begin
    serial_mode_nxt    = serial_mode_r;
    bit_rate_nxt       = bit_rate_r;
    serial_control_nxt = serial_control_r;
    smart_card_nxt     = smart_card_r;
    tx_data_nxt        = tx_data_r;
    rx_data_nxt        = rx_data_r;
    tx_data_empty_flag_nxt           = tx_data_empty_flag_r;
    rdrf_nxt           = rdrf_r;
    fer_nxt            = fer_r;
    tend_nxt           = tend_r;
    tx_data_empty_flag_seen_nxt      = tx_data_empty_flag_seen_r;
    rdrf_seen_nxt      = rdrf_seen_r;
    rdata_nxt          = 8'h00;
    if (RD) begin
      case (ADDR)
        `SCC_OFS_MODE:   rdata_nxt = serial_mode_r;
        `SCC_OFS_RATE:   rdata_nxt = bit_rate_r;
        `SCC_OFS_CTRL:   rdata_nxt = serial_control_r;
        `SCC_OFS_STAT: begin
          rdata_nxt     = status;
          tx_data_empty_flag_seen_nxt = tx_data_empty_flag_seen_r | tx_data_empty_flag_r;
          rdrf_seen_nxt = rdrf_seen_r | rdrf_r;
        end
        `SCC_OFS_TXDATA: rdata_nxt = tx_data_r;
        `SCC_OFS_RXDATA: rdata_nxt = rx_data_r;
        `SCC_OFS_SCMODE: rdata_nxt = smart_card_r;
        `SCC_OFS_POWER:  rdata_nxt = {5'h00, HW_STANDBY, MODULE_STOP, SW_STANDBY};
        default:         rdata_nxt = 8'h00;
      endcase
    end
    if (WR) begin
      case (ADDR)
        `SCC_OFS_MODE:   serial_mode_nxt    = WDATA;
        `SCC_OFS_RATE:   bit_rate_nxt       = WDATA;
        `SCC_OFS_CTRL:   serial_control_nxt = WDATA;
        `SCC_OFS_SCMODE: smart_card_nxt     = WDATA;
        `SCC_OFS_TXDATA: tx_data_nxt        = WDATA;
        `SCC_OFS_STAT: begin
          // Empty and RDRF flags clear only by writing 0 after reading them as 1; FER clears on any 0 write
          if (!WDATA[`SCC_STAT_TX_DATA_EMPTY_FLAG] && tx_data_empty_flag_seen_r) begin
            tx_data_empty_flag_nxt      = 1'b0;
            tx_data_empty_flag_seen_nxt = 1'b0;
          end
          if (!WDATA[`SCC_STAT_RDRF] && rdrf_seen_r) begin
            rdrf_nxt      = 1'b0;
            rdrf_seen_nxt = 1'b0;
          end
          if (!WDATA[`SCC_STAT_FER]) fer_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    if (ctrl_clear) serial_control_nxt = `SCC_CTRL_RST;
    // Hardware sets win over software clears
    if (load) begin
      tx_data_empty_flag_nxt = 1'b1;
      tend_nxt = 1'b0;
    end
    if (tx_st_r == scc_pkg::SCC_STOP && tick && tx_ph_r == 4'hf && tx_data_empty_flag_r) tend_nxt = 1'b1;
    if (rx_st_r == scc_pkg::SCC_STOP && tick && rx_ph_r == `SCC_SAMPLE_PT) begin
      if (rxd_s_r) begin
        rx_data_nxt = rx_shift_r;
        rdrf_nxt    = 1'b1;
      end else begin
        fer_nxt     = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Transmitter and receiver
  // --------------------------------------------------------------------------
  always_comb begin
    tx_st_nxt    = tx_st_r;
    tx_shift_nxt = tx_shift_r;
    tx_bit_nxt   = tx_bit_r;
    tx_ph_nxt    = tx_tick_ph(tx_ph_r, tick);
    txd_nxt      = txd_r;
    rx_st_nxt    = rx_st_r;
    rx_shift_nxt = rx_shift_r;
    rx_bit_nxt   = rx_bit_r;
    rx_ph_nxt    = tx_tick_ph(rx_ph_r, tick);
    case (tx_st_r)
      scc_pkg::SCC_IDLE: begin
        txd_nxt   = 1'b1;
        tx_ph_nxt = 4'h0;
        if (load) begin
          tx_shift_nxt = tx_data_r;
          tx_st_nxt    = scc_pkg::SCC_START;
          txd_nxt      = 1'b0;
        end
      end
      scc_pkg::SCC_START: if (tick && tx_ph_r == 4'hf) begin
        tx_st_nxt  = scc_pkg::SCC_DATA;
        txd_nxt    = tx_shift_r[0];
        tx_bit_nxt = 3'h0;
      end
      scc_pkg::SCC_DATA: if (tick && tx_ph_r == 4'hf) begin
        tx_shift_nxt = {1'b1, tx_shift_r[7:1]};
        tx_bit_nxt   = tx_bit_r + 3'h1;
        txd_nxt      = tx_shift_r[1];
        if (tx_bit_r == 3'h7) begin
          tx_st_nxt = scc_pkg::SCC_STOP;
          txd_nxt   = 1'b1;
        end
      end
      scc_pkg::SCC_STOP: if (tick && tx_ph_r == 4'hf) tx_st_nxt = scc_pkg::SCC_IDLE;
      default: tx_st_nxt = scc_pkg::SCC_IDLE;
    endcase
    case (rx_st_r)
      scc_pkg::SCC_IDLE: begin
        rx_ph_nxt = 4'h0;
        if (rx_en && tick && !rxd_s_r) rx_st_nxt = scc_pkg::SCC_START;
      end
      // Mid-bit sampling at phase 7 of 16 ticks per bit
      scc_pkg::SCC_START: if (tick && rx_ph_r == `SCC_SAMPLE_PT) begin
        if (rxd_s_r) begin
          rx_st_nxt = scc_pkg::SCC_IDLE;
        end
      end else if (tick && rx_ph_r == 4'hf) begin
        rx_st_nxt  = scc_pkg::SCC_DATA;
        rx_bit_nxt = 3'h0;
      end
      scc_pkg::SCC_DATA: if (tick && rx_ph_r == `SCC_SAMPLE_PT) begin
        rx_shift_nxt = {rxd_s_r, rx_shift_r[7:1]};
      end else if (tick && rx_ph_r == 4'hf) begin
        rx_bit_nxt = rx_bit_r + 3'h1;
        if (rx_bit_r == 3'h7) rx_st_nxt = scc_pkg::SCC_STOP;
      end
      scc_pkg::SCC_STOP: if (tick && rx_ph_r == `SCC_SAMPLE_PT) rx_st_nxt = scc_pkg::SCC_IDLE;
      default: rx_st_nxt = scc_pkg::SCC_IDLE;
    endcase
    if (!rx_en) rx_st_nxt = scc_pkg::SCC_IDLE;
    // Clock output at bit rate while the transmitter sends a frame; pin enabled when the clock output select is set
    sck_nxt    = tx_ph_r[3];
    sck_oe_n_nxt = !serial_control_nxt[0];
    tx_irq_nxt = tx_data_empty_flag_nxt & serial_control_nxt[`SCC_CTRL_TIE];
    rx_irq_nxt = rdrf_nxt & serial_control_nxt[`SCC_CTRL_RIE];
  end

  function automatic logic [3:0] tx_tick_ph(input logic [3:0] ph, input logic t);
    tx_tick_ph = t ? ph + 4'h1 : ph;
  endfunction

  always_ff @(posedge CORE_CLK) begin
    rxd_m_r <= RXD;
    rxd_s_r <= rxd_m_r;
    if (!NRST) begin
      serial_mode_r    <= `SCC_MODE_RST;
      bit_rate_r       <= `SCC_RATE_RST;
      serial_control_r <= `SCC_CTRL_RST;
      smart_card_r     <= 8'h00;
      tx_data_r        <= 8'hff;
      rx_data_r        <= 8'h00;
      tx_data_empty_flag_r           <= 1'b1;
      rdrf_r           <= 1'b0;
      fer_r            <= 1'b0;
      tend_r           <= 1'b1;
      tx_data_empty_flag_seen_r      <= 1'b0;
      rdrf_seen_r      <= 1'b0;
      rdata_r          <= 8'h00;
      tx_irq_r         <= 1'b0;
      rx_irq_r         <= 1'b0;
      sck_r            <= 1'b0;
      sck_oe_n_r       <= 1'b1;
      tx_st_r          <= scc_pkg::SCC_IDLE;
      tx_shift_r       <= 8'hff;
      tx_bit_r         <= 3'h0;
      tx_ph_r          <= 4'h0;
      txd_r            <= 1'b1;
      rx_st_r          <= scc_pkg::SCC_IDLE;
      rx_shift_r       <= 8'h00;
      rx_bit_r         <= 3'h0;
      rx_ph_r          <= 4'h0;
    end else begin
      serial_mode_r    <= serial_mode_nxt;
      bit_rate_r       <= bit_rate_nxt;
      serial_control_r <= serial_control_nxt;
      smart_card_r     <= smart_card_nxt;
      tx_data_r        <= tx_data_nxt;
      rx_data_r        <= rx_data_nxt;
      tx_data_empty_flag_r           <= tx_data_empty_flag_nxt;
      rdrf_r           <= rdrf_nxt;
      fer_r            <= fer_nxt;
      tend_r           <= tend_nxt;
      tx_data_empty_flag_seen_r      <= tx_data_empty_flag_seen_nxt;
      rdrf_seen_r      <= rdrf_seen_nxt;
      rdata_r          <= rdata_nxt;
      tx_irq_r         <= tx_irq_nxt;
      rx_irq_r         <= rx_irq_nxt;
      sck_r            <= sck_nxt;
      sck_oe_n_r       <= sck_oe_n_nxt;
      tx_st_r          <= tx_st_nxt;
      tx_shift_r       <= tx_shift_nxt;
      tx_bit_r         <= tx_bit_nxt;
      tx_ph_r          <= tx_ph_nxt;
      txd_r            <= txd_nxt;
      rx_st_r          <= rx_st_nxt;
      rx_shift_r       <= rx_shift_nxt;
      rx_bit_r         <= rx_bit_nxt;
      rx_ph_r          <= rx_ph_nxt;
    end
  end

  // Clock pin enable follows the control register in the same cycle
  assign RDATA        = rdata_r;
  assign TXD          = txd_r;
  assign SCK_OUT      = sck_r;
  assign SCK_OE_N     = sck_oe_n_r;
  assign TX_EMPTY_IRQ = tx_irq_r;
  assign RX_FULL_IRQ  = rx_irq_r;
endmodule

// >>> logic/scc_consts.svh
// Register offsets, field positions, reset values and timing counts for the serial control block
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SCC_OFS_MODE    4'h0
`define SCC_OFS_RATE    4'h1
`define SCC_OFS_CTRL    4'h2
`define SCC_OFS_STAT    4'h3
`define SCC_OFS_TXDATA  4'h4
`define SCC_OFS_RXDATA  4'h5
`define SCC_OFS_SCMODE  4'h6
`define SCC_OFS_POWER   4'h7

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SCC_MODE_CKS_LO 0
`define SCC_MODE_MP     2
`define SCC_CTRL_TIE    7
`define SCC_CTRL_RIE    6
`define SCC_CTRL_TE     5
`define SCC_CTRL_RE     4
`define SCC_CTRL_CLK_SOURCE_SEL_HI   1
`define SCC_STAT_TX_DATA_EMPTY_FLAG   7
`define SCC_STAT_RDRF   6
`define SCC_STAT_FER    4
`define SCC_STAT_TEND   2
`define SCC_PWR_SWSTBY  0
`define SCC_PWR_MSTOP   1
`define SCC_PWR_HWSTBY  2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SCC_CTRL_RST    8'h00
`define SCC_MODE_RST    8'h00
`define SCC_RATE_RST    8'hff
`define SCC_STAT_RST    8'h84

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SCC_OVERSAMPLE  16
`define SCC_SAMPLE_PT   4'h7
`define SCC_SYNC_GUARD  5

`endif

// >>> logic/scc_pkg.sv
// Types shared by the serial control block
package scc_pkg;
  typedef enum logic [1:0] {
    SCC_PRE_DIV1  = 2'b00,
    SCC_PRE_DIV4  = 2'b01,
    SCC_PRE_DIV16 = 2'b10,
    SCC_PRE_DIV64 = 2'b11
  } scc_pre_e;
  typedef enum logic [1:0] {
    SCC_IDLE  = 2'b00,
    SCC_START = 2'b01,
    SCC_DATA  = 2'b10,
    SCC_STOP  = 2'b11
  } scc_state_e;
endpackage

// >>> logic/scc_baud_gen.sv
// Prescaler and bit rate divider producing a tick at sixteen times the bit rate
`timescale 1ns/100ps
`include "scc_consts.svh"
module scc_baud_gen (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Control
  input  wire logic               run,
  input  wire scc_pkg::scc_pre_e  pre_sel,
  input  wire logic [7:0]         rate,
  // Tick
  output logic                    tick
);
  logic [5:0] pre_cnt_r,  pre_cnt_nxt;
  logic [7:0] rate_cnt_r, rate_cnt_nxt;
  logic       tick_r,     tick_nxt;
  logic       pre_en;

  always_comb begin
    case (pre_sel)
      scc_pkg::SCC_PRE_DIV1:  pre_en = 1'b1;
      scc_pkg::SCC_PRE_DIV4:  pre_en = (pre_cnt_r[1:0] == 2'h3);
      scc_pkg::SCC_PRE_DIV16: pre_en = (pre_cnt_r[3:0] == 4'hf);
      scc_pkg::SCC_PRE_DIV64: pre_en = (pre_cnt_r == 6'h3f);
      default:                pre_en = 1'b1;
    endcase
    pre_cnt_nxt  = run ? pre_cnt_r + 6'h01 : 6'h00;
    rate_cnt_nxt = rate_cnt_r;
    tick_nxt     = 1'b0;
    if (!run) begin
      rate_cnt_nxt = 8'h00;
    end else if (pre_en) begin
      if (rate_cnt_r >= rate) begin
        rate_cnt_nxt = 8'h00;
        tick_nxt     = 1'b1;
      end else begin
        rate_cnt_nxt = rate_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_cnt_r  <= 6'h00;
      rate_cnt_r <= 8'h00;
      tick_r     <= 1'b0;
    end else begin
      pre_cnt_r  <= pre_cnt_nxt;
      rate_cnt_r <= rate_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule

// >>> sim/scc_top_props.sv
// Port checker of the serial control block
`timescale 1ns/100ps
module scc_top_props #(
  parameter bit RETAIN_IN_SW_STANDBY = 1'b0
) (
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       NRST,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Power modes
  input wire logic       SW_STANDBY,
  input wire logic       MODULE_STOP,
  input wire logic       HW_STANDBY,
  // Serial pins and requests
  input wire logic       RXD,
  input wire logic       TXD,
  input wire logic       SCK_OUT,
  input wire logic       SCK_OE_N,
  input wire logic       TX_EMPTY_IRQ,
  input wire logic       RX_FULL_IRQ
);
  logic pwr_clr;
  logic ctl_wr;

  // Power states that wipe the control register in this variant
  assign pwr_clr = HW_STANDBY | (!RETAIN_IN_SW_STANDBY & (SW_STANDBY | MODULE_STOP));
  assign ctl_wr  = WR & (ADDR == 4'h2);

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  rst_out_a: assert property (disable iff (1'b0)
    !NRST |=> TXD && !SCK_OUT && SCK_OE_N && !TX_EMPTY_IRQ && !RX_FULL_IRQ && RDATA == 8'h00)
    else $error("outputs not at reset level");
  rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data outside read slot");
  pwr_clear_a: assert property (pwr_clr && !WR ##1 !WR |=> !TX_EMPTY_IRQ && !RX_FULL_IRQ)
    else $error("requests survive power clear");
  pwr_hold_a: assert property (pwr_clr [*3] |-> !TX_EMPTY_IRQ && !RX_FULL_IRQ)
    else $error("requests during held power mode");
  tie_off_a: assert property (ctl_wr && !WDATA[7] |=> !TX_EMPTY_IRQ)
    else $error("tx empty request not withdrawn");
  rie_off_a: assert property (ctl_wr && !WDATA[6] |=> !RX_FULL_IRQ)
    else $error("rx full request not gated");
  sck_oe_a: assert property (ctl_wr && WDATA[0] && !pwr_clr |-> ##[1:2] !SCK_OE_N)
    else $error("clock pin not enabled");
  tx_flag_a: assert property (RD && ADDR == 4'h3 && TX_EMPTY_IRQ |=> RDATA[7])
    else $error("tx request without empty flag");
endmodule

bind scc_top scc_top_props #(.RETAIN_IN_SW_STANDBY(RETAIN_IN_SW_STANDBY)) u_props (
  .CORE_CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .SW_STANDBY, .MODULE_STOP, .HW_STANDBY,
  .RXD, .TXD, .SCK_OUT, .SCK_OE_N, .TX_EMPTY_IRQ, .RX_FULL_IRQ
);

// >>> sim/scc_remote.sv
// Remote serial partner: frame sender and frame decoder
`timescale 1ns/100ps
module scc_remote (
  // Clock
  input  wire logic clk,
  // Serial lines
  input  wire logic txd,
  output logic      rxd
);
  int         bit_cyc  = 64;
  logic [7:0] got_byte = 8'h00;
  int         got_cnt  = 0;

  // Line idles high between frames
  initial rxd = 1'b1;

  // Start, eight data bits LSB first, stop of the given level
  task automatic send(input logic [7:0] b, input logic stop, input int cyc);
    logic [9:0] frm;
    frm = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= frm[i];
      repeat (cyc - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask

  // Decodes frames sent by the block, sampling mid-bit
  always begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk);
      got_byte[i] = txd;
    end
    repeat (bit_cyc) @(posedge clk);
    if (txd === 1'b1) got_cnt++;
  end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench of the serial control block
`timescale 1ns/100ps
module tb_top;
  logic       core_clk = 1'b0;
  logic       nrst     = 1'b0;
  logic [3:0] addr     = 4'h0;
  logic [7:0] wdata    = 8'h00;
  logic       wr       = 1'b0;
  logic       rd       = 1'b0;
  logic [2:0] pwr      = 3'h0;
  logic [7:0] rdata;
  logic [7:0] rdata_ret;
  logic       rxd;
  logic       txd;
  logic       sck_out;
  logic       sck_oe_n;
  logic       tx_irq;
  logic       rx_irq;
  logic [7:0] rv;
  logic [7:0] rv_ret;
  int         error_cnt   = 0;
  int         comparisons = 0;
  int         cyc         = 0;
  int         pre [4]     = '{1, 4, 16, 64};

  scc_top dut (
    .CORE_CLK(core_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .SW_STANDBY(pwr[0]), .MODULE_STOP(pwr[1]), .HW_STANDBY(pwr[2]), .RXD(rxd), .TXD(txd),
    .SCK_OUT(sck_out), .SCK_OE_N(sck_oe_n), .TX_EMPTY_IRQ(tx_irq), .RX_FULL_IRQ(rx_irq)
  );
  scc_top #(.RETAIN_IN_SW_STANDBY(1'b1)) dut_ret (
    .CORE_CLK(core_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata_ret),
    .SW_STANDBY(pwr[0]), .MODULE_STOP(pwr[1]), .HW_STANDBY(pwr[2]), .RXD(rxd), .TXD(),
    .SCK_OUT(), .SCK_OE_N(), .TX_EMPTY_IRQ(), .RX_FULL_IRQ()
  );
  scc_remote remote (.clk(core_clk), .txd(txd), .rxd(rxd));

  // ----------------------------------------------------------------------------
  // Clock, timeout and common tasks
  // ----------------------------------------------------------------------------
  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("TB: %0d mismatches, %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrt(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rx_data_reg(input logic [3:0] a);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
    rv_ret = rdata_ret;
  endtask

  // Waits for the partner to finish a frame, then checks its byte
  task automatic wait_tx(input logic [7:0] exp);
    int k;
    k = remote.got_cnt;
    for (int w = 0; w < 12000 && remote.got_cnt == k; w++) @(negedge core_clk);
    chk({7'h00, remote.got_cnt != k}, 8'h01, "frame seen");
    chk(remote.got_byte, exp, "line byte");
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    rx_data_reg(4'h0);
    chk(rv, 8'h00, "mode reset");
    rx_data_reg(4'h2);
    chk(rv, 8'h00, "ctrl reset");
    rx_data_reg(4'h3);
    chk(rv, 8'h84, "status reset");
    wrt(4'h9, 8'h5a);
    rx_data_reg(4'h9);
    chk(rv, 8'h00, "unmapped");
    wrt(4'h2, 8'h4d);
    rx_data_reg(4'h2);
    chk(rv, 8'h4d, "ctrl rw");
    chk({7'h00, sck_oe_n}, 8'h00, "clock pin enable");
    wrt(4'h2, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_txirq();
    remote.bit_cyc = 16;
    wrt(4'h1, 8'h00);
    wrt(4'h2, 8'h80);
    #1;
    chk({7'h00, tx_irq}, 8'h01, "irq on enable");
    rx_data_reg(4'h3);
    wrt(4'h3, 8'h00);
    #1;
    chk({7'h00, tx_irq}, 8'h00, "irq flag clear");
    wrt(4'h4, 8'h3c);
    wrt(4'h2, 8'ha0);
    for (int n = 0; n < 100 && tx_irq !== 1'b1; n++) @(negedge core_clk);
    chk({7'h00, tx_irq}, 8'h01, "irq on load");
    wrt(4'h2, 8'h20);
    #1;
    chk({7'h00, tx_irq}, 8'h00, "irq enable clear");
    wait_tx(8'h3c);
    $display("t_txirq done");
  endtask

  task automatic t_prescale();
    int w;
    for (int i = 0; i < 4; i++) begin
      remote.bit_cyc = 16 * pre[i];
      wrt(4'h0, i[7:0]);
      wrt(4'h4, 8'ha5);
      rx_data_reg(4'h3);
      wrt(4'h3, 8'h00);
      for (int n = 0; n < 2000 && txd !== 1'b0; n++) @(negedge core_clk);
      chk({7'h00, sck_out}, 8'h00, "clock low in start bit");
      w = 0;
      while (w < 5000 && txd === 1'b0) begin
        @(negedge core_clk);
        w++;
      end
      chk({7'h00, sck_out}, 8'h01, "clock high at bit end");
      comparisons++;
      if (w != 16 * pre[i]) begin
        error_cnt++;
        $display("MISMATCH t=%0t start bit %0d cycles", $time, w);
      end
      wait_tx(8'ha5);
    end
    $display("t_prescale done");
  endtask

  task automatic t_rx();
    logic [7:0] rb [3] = '{8'h3c, 8'hc3, 8'h55};
    int         rc [3] = '{64, 62, 64};
    wrt(4'h0, 8'h00);
    wrt(4'h1, 8'h03);
    wrt(4'h2, 8'h50);
    for (int i = 0; i < 3; i++) begin
      remote.send(rb[i], i != 2, rc[i]);
      rx_data_reg(4'h3);
      chk(rv & 8'h50, (i == 2) ? 8'h10 : 8'h40, "rx status");
      chk({7'h00, rx_irq}, (i == 2) ? 8'h00 : 8'h01, "rx request");
      rx_data_reg(4'h5);
      if (i < 2) chk(rv, rb[i], "rx byte");
      wrt(4'h3, 8'h00);
    end
    $display("t_rx done");
  endtask

  task automatic t_power();
    for (int i = 0; i < 3; i++) begin
      wrt(4'h2, 8'h40);
      @(posedge core_clk);
      pwr <= 3'h1 << i;
      repeat (3) @(posedge core_clk);
      pwr <= 3'h0;
      rx_data_reg(4'h2);
      chk(rv, 8'h00, "ctrl cleared");
      chk(rv_ret, (i == 2) ? 8'h00 : 8'h40, "ctrl kept");
    end
    // Set-up order before entering soft standby
    wrt(4'h2, 8'h00);
    wrt(4'h0, 8'h04);
    wrt(4'h1, 8'h07);
    wrt(4'h6, 8'h3c);
    @(posedge core_clk);
    pwr <= 3'h1;
    rx_data_reg(4'h7);
    chk(rv, 8'h01, "power status");
    rx_data_reg(4'h3);
    chk(rv & 8'h01, 8'h01, "mode copy in status");
    rx_data_reg(4'h6);
    chk(rv, 8'h3c, "smart card kept");
    @(posedge core_clk);
    pwr <= 3'h0;
    $display("t_power done");
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_txirq();
    t_prescale();
    t_rx();
    t_power();
    wrap_up();
  end
endmodule
